// [pkg/ucsf_pkg.sv]
`default_nettype none
package ucsf_pkg;
   // Register offsets.
   localparam logic [3:0] CMD_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h1;
   localparam logic [3:0] MASK_OFS = 4'h2;
   localparam logic [3:0] TIMEOUT_OFS = 4'h3;
   localparam logic [3:0] RHR_OFS = 4'h4;
   localparam logic [3:0] THR_OFS = 4'h5;
   // Status bit positions.
   localparam int RECEIVER_READY_FLAG_BIT = 0;
   localparam int TRANSMITTER_READY_FLAG_BIT = 1;
   localparam int BRK_BIT = 2;
   localparam int OVR_BIT = 5;
   localparam int FRAME_BIT = 6;
   localparam int PAR_BIT = 7;
   localparam int TOUT_BIT = 8;
   localparam int TXEMPTY_BIT = 9;
   // Command bit positions.
   localparam int CMD_RESET_STATUS_COMMAND_BIT = 0;
   localparam int CMD_START_TIMEOUT_COMMAND_BIT = 1;
   localparam int CMD_START_BREAK_COMMAND_BIT = 2;
   localparam int CMD_STPBRK_BIT = 3;
   localparam int CMD_RXEN_BIT = 4;
   localparam int CMD_RXDIS_BIT = 5;
   localparam int CMD_TXEN_BIT = 6;
   localparam int CMD_TXDIS_BIT = 7;
   // Reset values.
   localparam logic [9:0] STATUS_RST = 10'h000;
   localparam logic [9:0] MASK_RST = 10'h000;
   localparam logic [7:0] TIMEOUT_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   // Timing: shifting one character out takes this many clock cycles.
   localparam logic [7:0] SHIFT_CYCLES = 8'h0a;
endpackage
`default_nettype wire

// [logic/ucsf_sync.sv]
`default_nettype none
module ucsf_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic [2:0] stage;
   logic outReg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage <= 3'h0;
         outReg <= 1'b0;
      end else begin
         stage <= {stage[1:0], din};
         if (stage[1] == stage[2]) begin
            outReg <= stage[2];
         end
      end
   end
   assign dout = outReg;
endmodule
`default_nettype wire

// [logic/ucsf_status.sv]
// Decided for this implementation: the placing of the registers and the plain strobed port.
`default_nettype none
//
// Behaviour
// - Transmitter empty is one only when holding and shift registers are empty.
// - Timeout flag sets on expiry after start-timeout; zero timeout value reads zero.
// - Parity error flag sets on a parity error while the receiver is enabled, until reset-status.
// - Framing flag sets when a stop bit is sampled low until reset-status.
// - Overrun flag sets on receive overrun until reset-status.
// - Break flag sets on break start and break end until reset-status.
// - Transmitter ready drops on holding register write, one when holding empty.
// - Transmitter ready is zero while break pending or transmitter disabled.
// - Receiver ready sets on complete character, cleared by holding register read.
// - Receiver ready reads zero while disabled; pending character shows on re-enable.
module ucsf_status #(
   parameter int TIMEOUT_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic rxLine,
   input wire logic [7:0] rxChar,
   input wire logic rxCharDone,
   input wire logic rxParityErr,
   input wire logic rxStopLow,
   input wire logic rxBreakEdge,
   input wire logic rxBitTick,
   output logic [7:0] txChar,
   output logic txShiftBusy,
   output logic txBreakActive,
   output logic irq
);
   typedef enum {TX_IDLE, TX_SHIFT, TX_BREAK} ucsf_txst_t;
   typedef struct packed {
      logic [9:0] status;
      logic [9:0] mask;
      logic [TIMEOUT_W-1:0] toValue;
      logic [TIMEOUT_W-1:0] toCount;
      logic toArmed;
      logic rxEn;
      logic txEn;
      logic rxPending;
      logic [7:0] rxData;
      logic thrFull;
      logic [7:0] thrData;
      logic [7:0] shiftData;
      logic [7:0] shiftCnt;
      logic brkReq;
      ucsf_txst_t txState;
      logic [31:0] rdata;
      logic shiftBusy;
      logic brkActive;
      logic irq;
   } ucsf_state_t;

   ucsf_state_t st_reg;
   ucsf_state_t st_next;
   logic lineSync;

   // ------------------------------------------------------------
   // Line input synchroniser.
   // ------------------------------------------------------------
   ucsf_sync uLineSync (
      .clk(clk),
      .rst(rst),
      .din(rxLine),
      .dout(lineSync)
   );

   function automatic logic wrAt(input logic [3:0] a, input logic [3:0] ofs, input logic w);
      wrAt = w && (a == ofs);
   endfunction

   // ------------------------------------------------------------
   // Next-state logic.
   // ------------------------------------------------------------
   always_comb begin
      logic cmdWr;
      logic reset_status_command;
      logic [9:0] rawStatus;
      cmdWr = wrAt(regAddr, ucsf_pkg::CMD_OFS, regWr);
      reset_status_command = cmdWr && regWdata[ucsf_pkg::CMD_RESET_STATUS_COMMAND_BIT];
      rawStatus = 10'h000;
      st_next = st_reg;

      if (cmdWr && regWdata[ucsf_pkg::CMD_RXEN_BIT]) begin
         st_next.rxEn = 1'b1;
      end
      if (cmdWr && regWdata[ucsf_pkg::CMD_RXDIS_BIT]) begin
         st_next.rxEn = 1'b0;
      end
      if (cmdWr && regWdata[ucsf_pkg::CMD_TXEN_BIT]) begin
         st_next.txEn = 1'b1;
      end
      if (cmdWr && regWdata[ucsf_pkg::CMD_TXDIS_BIT]) begin
         st_next.txEn = 1'b0;
      end
      if (wrAt(regAddr, ucsf_pkg::MASK_OFS, regWr)) begin
         st_next.mask = regWdata[9:0];
      end
      if (wrAt(regAddr, ucsf_pkg::TIMEOUT_OFS, regWr)) begin
         st_next.toValue = regWdata[TIMEOUT_W-1:0];
      end

      // Error flags: clear first so a same-cycle event still sets.
      if (reset_status_command) begin
         st_next.status[ucsf_pkg::PAR_BIT] = 1'b0;
         st_next.status[ucsf_pkg::FRAME_BIT] = 1'b0;
         st_next.status[ucsf_pkg::OVR_BIT] = 1'b0;
         st_next.status[ucsf_pkg::BRK_BIT] = 1'b0;
      end
      if (st_reg.rxEn && rxParityErr) begin
         st_next.status[ucsf_pkg::PAR_BIT] = 1'b1;
      end
      if (st_reg.rxEn && rxStopLow) begin
         st_next.status[ucsf_pkg::FRAME_BIT] = 1'b1;
      end
      if (st_reg.rxEn && rxBreakEdge) begin
         st_next.status[ucsf_pkg::BRK_BIT] = 1'b1;
      end

      // Receive holding register; pending survives a disable.
      if (regRd && regAddr == ucsf_pkg::RHR_OFS) begin
         st_next.rxPending = 1'b0;
      end
      if (st_reg.rxEn && rxCharDone) begin
         if (st_reg.rxPending && !(regRd && regAddr == ucsf_pkg::RHR_OFS)) begin
            st_next.status[ucsf_pkg::OVR_BIT] = 1'b1;
         end
         st_next.rxPending = 1'b1;
         st_next.rxData = rxChar;
      end

      // Receive timeout counts idle bit times on a high line.
      if (st_reg.toArmed && st_reg.toValue != '0 && rxBitTick && lineSync) begin
         st_next.toCount = st_reg.toCount + 1'b1;
         if (st_reg.toCount + 1'b1 >= st_reg.toValue) begin
            st_next.toArmed = 1'b0;
            st_next.status[ucsf_pkg::TOUT_BIT] = 1'b1;
         end
      end
      if (!lineSync || rxCharDone) begin
         st_next.toCount = '0;
      end
      if (cmdWr && regWdata[ucsf_pkg::CMD_START_TIMEOUT_COMMAND_BIT]) begin
         st_next.status[ucsf_pkg::TOUT_BIT] = 1'b0;
         st_next.toArmed = 1'b1;
         st_next.toCount = '0;
      end
      if (st_reg.toValue == '0) begin
         st_next.status[ucsf_pkg::TOUT_BIT] = 1'b0;
      end

      // Transmit side.
      if (cmdWr && regWdata[ucsf_pkg::CMD_START_BREAK_COMMAND_BIT]) begin
         st_next.brkReq = 1'b1;
      end
      case (st_reg.txState)
         TX_IDLE: begin
            if (st_reg.txEn && st_reg.brkReq) begin
               st_next.txState = TX_BREAK;
            end else if (st_reg.txEn && st_reg.thrFull) begin
               st_next.thrFull = 1'b0;
               st_next.shiftData = st_reg.thrData;
               st_next.shiftCnt = ucsf_pkg::SHIFT_CYCLES;
               st_next.txState = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            st_next.shiftCnt = st_reg.shiftCnt - 8'h01;
            if (st_reg.shiftCnt == 8'h01) begin
               st_next.txState = TX_IDLE;
            end
         end
         TX_BREAK: begin
            if (cmdWr && regWdata[ucsf_pkg::CMD_STPBRK_BIT]) begin
               st_next.brkReq = 1'b0;
               st_next.txState = TX_IDLE;
            end
         end
         default: begin
            st_next.txState = TX_IDLE;
         end
      endcase
      // A holding write after the load wins, so a character written as the old one moves is kept.
      if (wrAt(regAddr, ucsf_pkg::THR_OFS, regWr) && st_reg.txEn) begin
         st_next.thrFull = 1'b1;
         st_next.thrData = regWdata[7:0];
      end
      if (!st_next.txEn) begin
         st_next.thrFull = 1'b0;
      end

      // Derived flags.
      st_next.status[ucsf_pkg::RECEIVER_READY_FLAG_BIT] = st_next.rxEn && st_next.rxPending;
      st_next.status[ucsf_pkg::TRANSMITTER_READY_FLAG_BIT] = st_next.txEn && !st_next.thrFull
         && !st_next.brkReq;
      st_next.status[ucsf_pkg::TXEMPTY_BIT] = st_next.txEn && !st_next.thrFull
         && st_next.txState == TX_IDLE;
      st_next.shiftBusy = (st_next.txState == TX_SHIFT);
      st_next.brkActive = (st_next.txState == TX_BREAK);
      rawStatus = st_next.status & st_next.mask;
      st_next.irq = |rawStatus;

      st_next.rdata = 32'h0000_0000;
      if (regRd) begin
         case (regAddr)
            ucsf_pkg::STATUS_OFS: st_next.rdata = {22'h0, st_reg.status};
            ucsf_pkg::MASK_OFS: st_next.rdata = {22'h0, st_reg.mask};
            ucsf_pkg::TIMEOUT_OFS: st_next.rdata = 32'(st_reg.toValue);
            ucsf_pkg::RHR_OFS: st_next.rdata = {24'h000000, st_reg.rxData};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register.
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '{status: ucsf_pkg::STATUS_RST, mask: ucsf_pkg::MASK_RST,
            toValue: '0, toCount: '0, toArmed: 1'b0, rxEn: 1'b0, txEn: 1'b0,
            rxPending: 1'b0, rxData: ucsf_pkg::DATA_RST, thrFull: 1'b0,
            thrData: ucsf_pkg::DATA_RST, shiftData: ucsf_pkg::DATA_RST,
            shiftCnt: 8'h00, brkReq: 1'b0, txState: TX_IDLE,
            rdata: 32'h0000_0000, shiftBusy: 1'b0, brkActive: 1'b0, irq: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign regRdata = st_reg.rdata;
   assign txChar = st_reg.shiftData;
   assign txShiftBusy = st_reg.shiftBusy;
   assign txBreakActive = st_reg.brkActive;
   assign irq = st_reg.irq;
endmodule
`default_nettype wire

// [verification/ucsf_status_properties.sv]
`default_nettype none
module ucsf_status_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   input wire logic rxCharDone,
   input wire logic rxParityErr,
   input wire logic rxStopLow,
   input wire logic rxBreakEdge,
   input wire logic rxBitTick,
   input wire logic txShiftBusy,
   input wire logic txBreakActive,
   input wire logic irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   wire logic sr = regRd && regAddr == ucsf_pkg::STATUS_OFS;
   wire logic cw = regWr && regAddr == ucsf_pkg::CMD_OFS;
   wire logic ev = rxCharDone || rxParityErr || rxStopLow || rxBreakEdge;
   a_txempty_busy: assert property (sr && txShiftBusy |=> !regRdata[9])
      else $error("tx empty while shifting");
   a_timeout_restart: assert property (cw && regWdata[1] && !rxBitTick ##1 sr && !rxBitTick
      |=> !regRdata[8]) else $error("timeout kept after restart");
   a_errors_cleared: assert property (cw && regWdata[0] && !ev ##1 sr
      |=> regRdata[7:5] == 3'h0 && !regRdata[2]) else $error("error flag kept");
   a_transmitter_ready_flag_write: assert property (regWr && regAddr == ucsf_pkg::THR_OFS && txShiftBusy
      ##1 sr && txShiftBusy |=> !regRdata[1]) else $error("tx ready after write");
   a_transmitter_ready_flag_break: assert property (sr && txBreakActive |=> !regRdata[1])
      else $error("tx ready during break");
   a_receiver_ready_flag_clear: assert property (regRd && regAddr == ucsf_pkg::RHR_OFS && !rxCharDone
      ##1 sr |=> !regRdata[0]) else $error("rx ready kept");
   a_receiver_ready_flag_disabled: assert property (cw && regWdata[5] ##1 sr |=> !regRdata[0])
      else $error("rx ready while disabled");
   a_unmapped_zero: assert property (regRd && regAddr > 4'h5 |=> regRdata == 32'h0)
      else $error("unmapped read not zero");
   a_irq_masked_off: assert property (regWr && regAddr == ucsf_pkg::MASK_OFS &&
      regWdata[9:0] == 10'h000 |=> !irq) else $error("irq with mask clear");
   c_shift_read: cover property (sr && txShiftBusy);
   c_irq_high: cover property (irq);
   c_status_reset: cover property (cw && regWdata[0]);
endmodule
bind ucsf_status ucsf_status_properties ucsf_status_properties_inst (.clk(clk), .rst(rst),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .rxCharDone(rxCharDone), .rxParityErr(rxParityErr), .rxStopLow(rxStopLow),
   .rxBreakEdge(rxBreakEdge), .rxBitTick(rxBitTick), .txShiftBusy(txShiftBusy),
   .txBreakActive(txBreakActive), .irq(irq));
`default_nettype wire

// [verification/ucsf_partner.sv]
`default_nettype none
module ucsf_partner (
   input wire logic clk,
   output logic rxLine,
   output logic [7:0] rxChar,
   output logic rxCharDone,
   output logic rxParityErr,
   output logic rxStopLow,
   output logic rxBreakEdge,
   output logic rxBitTick
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rxLine = 1'b1;
      rxChar = 8'h00;
      {rxCharDone, rxParityErr, rxStopLow, rxBreakEdge, rxBitTick} = 5'h00;
   end
   // Kind 0 character, 1 parity, 2 low stop bit, 3 break edge, 4 bit tick.
   task automatic send(input int k, input logic [7:0] c);
      @(posedge clk);
      rxChar <= c;
      {rxCharDone, rxParityErr, rxStopLow, rxBreakEdge, rxBitTick} <= 5'h10 >> k;
      @(posedge clk);
      {rxCharDone, rxParityErr, rxStopLow, rxBreakEdge, rxBitTick} <= 5'h00;
      rxChar <= ~c;
   endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] CM = ucsf_pkg::CMD_OFS;
   localparam logic [3:0] ST = ucsf_pkg::STATUS_OFS;
   localparam logic [3:0] RH = ucsf_pkg::RHR_OFS;
   logic clk, rst, regWr, regRd, rxLine, rxCharDone, rxParityErr, rxStopLow, rxBreakEdge;
   logic rxBitTick, txShiftBusy, txBreakActive, irq;
   logic [3:0] regAddr;
   logic [31:0] regWdata, regRdata;
   logic [7:0] rxChar, txChar;
   int err_total = 0;
   int comparisons = 0;
   ucsf_status ucsf_status_inst (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxLine(rxLine), .rxChar(rxChar),
      .rxCharDone(rxCharDone), .rxParityErr(rxParityErr), .rxStopLow(rxStopLow),
      .rxBreakEdge(rxBreakEdge), .rxBitTick(rxBitTick), .txChar(txChar),
      .txShiftBusy(txShiftBusy), .txBreakActive(txBreakActive), .irq(irq));
   ucsf_partner ucsf_partner_inst (.clk(clk), .rxLine(rxLine), .rxChar(rxChar),
      .rxCharDone(rxCharDone), .rxParityErr(rxParityErr), .rxStopLow(rxStopLow),
      .rxBreakEdge(rxBreakEdge), .rxBitTick(rxBitTick));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Each access holds its strobe for exactly one sampling edge.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      {regWr, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      {regRd, regAddr} <= {1'b1, a};
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk("read data", e, regRdata & m);
   endtask
   task automatic complete_run;
      $display("counts: %0d mismatches, %0d comparisons", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      complete_run;
   end
   initial begin
      {rst, regWr, regRd, regAddr, regWdata} = {3'b100, 4'h0, 32'h0};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(ST, 32'h3ff, 32'h0);
      wr(CM, 32'h40);
      rd(ST, 32'h202, 32'h202);
      wr(4'h5, 32'ha5);
      rd(ST, 32'h200, 32'h0);
      wr(4'h5, 32'h3c);
      rd(ST, 32'h202, 32'h0);
      chk("txShiftBusy", 32'h1, {31'h0, txShiftBusy});
      repeat (30) @(posedge clk);
      rd(ST, 32'h202, 32'h202);
      chk("txChar", 32'h3c, {24'h0, txChar});
      chk("txShiftBusy", 32'h0, {31'h0, txShiftBusy});
      wr(CM, 32'h04);
      rd(ST, 32'h2, 32'h0);
      rd(ST, 32'h2, 32'h0);
      chk("txBreakActive", 32'h1, {31'h0, txBreakActive});
      wr(CM, 32'h08);
      repeat (30) @(posedge clk);
      rd(ST, 32'h2, 32'h2);
      chk("txBreakActive", 32'h0, {31'h0, txBreakActive});
      wr(CM, 32'h80);
      rd(ST, 32'h202, 32'h0);
      $display("test transmit done");
      wr(CM, 32'h10);
      rd(ST, 32'h1, 32'h0);
      ucsf_partner_inst.send(0, 8'h11);
      rd(ST, 32'h1, 32'h1);
      rd(RH, 32'hff, 32'h11);
      rd(ST, 32'h1, 32'h0);
      ucsf_partner_inst.send(0, 8'h22);
      ucsf_partner_inst.send(0, 8'h33);
      rd(ST, 32'h21, 32'h21);
      for (int k = 1; k < 4; k++) ucsf_partner_inst.send(k, 8'h00);
      rd(ST, 32'h1e5, 32'h0e5);
      wr(ucsf_pkg::MASK_OFS, 32'h0e4);
      rd(ST, 32'h1, 32'h1);
      chk("irq", 32'h1, {31'h0, irq});
      wr(CM, 32'h01);
      rd(ST, 32'h1e5, 32'h001);
      chk("irq", 32'h0, {31'h0, irq});
      wr(CM, 32'h20);
      rd(ST, 32'h1, 32'h0);
      wr(CM, 32'h10);
      rd(ST, 32'h1, 32'h1);
      $display("test receive done");
      wr(ucsf_pkg::TIMEOUT_OFS, 32'h3);
      rd(ucsf_pkg::TIMEOUT_OFS, 32'hff, 32'h3);
      wr(CM, 32'h02);
      rd(ST, 32'h100, 32'h0);
      repeat (6) ucsf_partner_inst.send(4, 8'h00);
      rd(ST, 32'h100, 32'h100);
      wr(ucsf_pkg::TIMEOUT_OFS, 32'h0);
      rd(ucsf_pkg::TIMEOUT_OFS, 32'hff, 32'h0);
      wr(CM, 32'h02);
      rd(ST, 32'h100, 32'h0);
      repeat (6) ucsf_partner_inst.send(4, 8'h00);
      rd(ST, 32'h100, 32'h0);
      rd(4'hf, 32'hffffffff, 32'h0);
      wr(ucsf_pkg::MASK_OFS, 32'h0);
      rd(ST, 32'h3ff, 32'h001);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test timeout done");
      complete_run;
   end
endmodule
`default_nettype wire
